// *** pkg/rxi_pkg.sv ***
package rxi_pkg;

    // register addresses on the host register port
    localparam logic [6:0] ADDR_IRQ_ENABLE_MASK   = 7'h3F;
    localparam logic [6:0] ADDR_OUTPUT_PIN_ROUTE  = 7'h40;
    localparam logic [6:0] ADDR_IRQ_LINE_SRC_SEL  = 7'h41;
    localparam logic [6:0] ADDR_IRQ_FLAG_CLEAR    = 7'h42;
    localparam logic [6:0] ADDR_IRQ_FLAG_REGISTER = 7'h43;

    // reset values
    localparam logic [7:0] RST_IRQ_ENABLE_MASK  = 8'h00;
    localparam logic [7:0] RST_OUTPUT_PIN_ROUTE = 8'h00;
    localparam logic [7:0] RST_IRQ_LINE_SRC_SEL = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAGS        = 8'h00;

    // event bit positions, shared by enable, clear and flag registers
    localparam int BIT_SLEEP_TIMEOUT  = 7;
    localparam int BIT_RECV_TIMEOUT   = 6;
    localparam int BIT_SIGNAL_VALID   = 5;
    localparam int BIT_PREAMBLE_PASS  = 4;
    localparam int BIT_SYNCWORD_PASS  = 3;
    localparam int BIT_NODE_MATCH     = 2;
    localparam int BIT_CHECKSUM_PASS  = 1;
    localparam int BIT_FRAME_FINISHED = 0;

    // field positions
    localparam int POS_OUT_PIN_FOUR_ROUTE  = 6;
    localparam int POS_OUT_PIN_THREE_ROUTE = 4;
    localparam int POS_OUT_PIN_TWO_ROUTE   = 2;
    localparam int POS_OUT_PIN_ONE_ROUTE   = 0;
    localparam int POS_IRQ_LINE_TWO_SOURCE = 4;
    localparam int POS_IRQ_LINE_ONE_SOURCE = 0;

    // data modes
    localparam logic [1:0] MODE_DIRECT = 2'h0;
    localparam logic [1:0] MODE_BUFFER = 2'h1;
    localparam logic [1:0] MODE_PACKET = 2'h2;

    // output pin route codes
    localparam logic [1:0] ROUTE_DEFAULT = 2'h0;
    localparam logic [1:0] ROUTE_ALT_ONE = 2'h1;
    localparam logic [1:0] ROUTE_ALT_TWO = 2'h2;
    localparam logic [1:0] ROUTE_ALT_THR = 2'h3;

    typedef enum logic [3:0] {
        SRC_ZERO       = 4'h0,
        SRC_SIG_VALID  = 4'h1,
        SRC_PREAMBLE   = 4'h2,
        SRC_SYNCWORD   = 4'h3,
        SRC_CODE_4     = 4'h4,
        SRC_CODE_5     = 4'h5,
        SRC_CODE_6     = 4'h6,
        SRC_CODE_7     = 4'h7,
        SRC_CODE_8     = 4'h8,
        SRC_CODE_9     = 4'h9,
        SRC_CODE_10    = 4'hA,
        SRC_CODE_11    = 4'hB,
        SRC_CODE_12    = 4'hC,
        SRC_CODE_13    = 4'hD,
        SRC_CODE_14    = 4'hE,
        SRC_FORCE_ZERO = 4'hF
    } rxi_src_t;

endpackage

// *** pkg/rxi_event_if.sv ***
`timescale 1ns/10ps
interface rxi_event_if;
    logic [1:0] dataMode;
    logic [7:0] flags;
    logic       signalStrengthIndicator;
    logic       queueNotEmpty;
    logic       queueThreshold;
    logic       queueFull;
    logic       queueByteWriteStrobe;
    logic       queueOverflow;

    modport source
    (
        output dataMode,
        output flags,
        output signalStrengthIndicator,
        output queueNotEmpty,
        output queueThreshold,
        output queueFull,
        output queueByteWriteStrobe,
        output queueOverflow
    );

    modport sink
    (
        input dataMode,
        input flags,
        input signalStrengthIndicator,
        input queueNotEmpty,
        input queueThreshold,
        input queueFull,
        input queueByteWriteStrobe,
        input queueOverflow
    );
endinterface

// *** rtl/rxi_line_mux.sv ***
`timescale 1ns/10ps
module rxi_line_mux
(
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // selection
    input  wire logic [3:0]   sourceCode,
    rxi_event_if.sink         ev,
    // line
    output logic              irqLine
);

    logic next_irqLine;
    rxi_pkg::rxi_src_t code;

    assign code = rxi_pkg::rxi_src_t'(sourceCode);

    always_comb
    begin
        next_irqLine = 1'b0;
        case (code)
            rxi_pkg::SRC_ZERO:      next_irqLine = 1'b0;
            rxi_pkg::SRC_SIG_VALID: next_irqLine = ev.flags[rxi_pkg::BIT_SIGNAL_VALID];
            rxi_pkg::SRC_PREAMBLE:  next_irqLine = ev.flags[rxi_pkg::BIT_PREAMBLE_PASS];
            rxi_pkg::SRC_SYNCWORD:  next_irqLine = ev.flags[rxi_pkg::BIT_SYNCWORD_PASS];
            rxi_pkg::SRC_FORCE_ZERO: next_irqLine = 1'b0;
            default:
            begin
                case (ev.dataMode)
                    rxi_pkg::MODE_DIRECT:
                    begin
                        case (code)
                            rxi_pkg::SRC_CODE_4: next_irqLine = ev.flags[rxi_pkg::BIT_SLEEP_TIMEOUT];
                            rxi_pkg::SRC_CODE_5: next_irqLine = ev.flags[rxi_pkg::BIT_RECV_TIMEOUT];
                            rxi_pkg::SRC_CODE_6: next_irqLine = ev.signalStrengthIndicator;
                            default:             next_irqLine = 1'b0;
                        endcase
                    end
                    rxi_pkg::MODE_BUFFER:
                    begin
                        case (code)
                            rxi_pkg::SRC_CODE_4:  next_irqLine = ev.flags[rxi_pkg::BIT_SLEEP_TIMEOUT];
                            rxi_pkg::SRC_CODE_5:  next_irqLine = ev.flags[rxi_pkg::BIT_RECV_TIMEOUT];
                            rxi_pkg::SRC_CODE_6:  next_irqLine = ev.queueNotEmpty;
                            rxi_pkg::SRC_CODE_7:  next_irqLine = ev.queueThreshold;
                            rxi_pkg::SRC_CODE_8:  next_irqLine = ev.queueFull;
                            rxi_pkg::SRC_CODE_9:  next_irqLine = ev.queueByteWriteStrobe;
                            rxi_pkg::SRC_CODE_10: next_irqLine = ev.queueOverflow;
                            rxi_pkg::SRC_CODE_11: next_irqLine = ev.signalStrengthIndicator;
                            default:              next_irqLine = 1'b0;
                        endcase
                    end
                    rxi_pkg::MODE_PACKET:
                    begin
                        case (code)
                            rxi_pkg::SRC_CODE_4:  next_irqLine = ev.flags[rxi_pkg::BIT_NODE_MATCH];
                            rxi_pkg::SRC_CODE_5:  next_irqLine = ev.flags[rxi_pkg::BIT_CHECKSUM_PASS];
                            rxi_pkg::SRC_CODE_6:  next_irqLine = ev.flags[rxi_pkg::BIT_FRAME_FINISHED];
                            rxi_pkg::SRC_CODE_7:  next_irqLine = ev.flags[rxi_pkg::BIT_SLEEP_TIMEOUT];
                            rxi_pkg::SRC_CODE_8:  next_irqLine = ev.flags[rxi_pkg::BIT_RECV_TIMEOUT];
                            rxi_pkg::SRC_CODE_9:  next_irqLine = ev.queueNotEmpty;
                            rxi_pkg::SRC_CODE_10: next_irqLine = ev.queueThreshold;
                            rxi_pkg::SRC_CODE_11: next_irqLine = ev.queueFull;
                            rxi_pkg::SRC_CODE_12: next_irqLine = ev.queueByteWriteStrobe;
                            rxi_pkg::SRC_CODE_13: next_irqLine = ev.queueOverflow;
                            rxi_pkg::SRC_CODE_14: next_irqLine = ev.signalStrengthIndicator;
                            default:              next_irqLine = 1'b0;
                        endcase
                    end
                    // the unused mode code keeps the line quiet for codes 4 to 14 rather than guessing
                    default: next_irqLine = 1'b0;
                endcase
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irqLine <= 1'b0;
        else
            irqLine <= next_irqLine;
    end

endmodule

// *** rtl/rxi_irq_route.sv ***
`timescale 1ns/10ps
module rxi_irq_route
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    // host register port
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [6:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    // receiver state and events
    input  wire logic [1:0] dataMode,
    input  wire logic       sleepTimeoutEvent,
    input  wire logic       receiveTimeoutEvent,
    input  wire logic       signalValidEvent,
    input  wire logic       preamblePassEvent,
    input  wire logic       syncwordPassEvent,
    input  wire logic       nodeMatchEvent,
    input  wire logic       checksumPassEvent,
    input  wire logic       frameFinishedEvent,
    input  wire logic       signalStrengthIndicator,
    input  wire logic       queueNotEmpty,
    input  wire logic       queueThreshold,
    input  wire logic       queueFull,
    input  wire logic       queueByteWriteStrobe,
    input  wire logic       queueOverflow,
    // signals offered to the output pins
    input  wire logic       demodData,
    input  wire logic       dataSyncClock,
    input  wire logic       systemClockOut,
    input  wire logic       powerOnResetOut,
    // interrupt lines and output pins
    output logic            irqLineOne,
    output logic            irqLineTwo,
    output logic            outPinOne,
    output logic            outPinTwo,
    output logic            outPinThree,
    output logic            outPinFour
);

    logic [7:0] irqEnableMask;
    logic [7:0] outputPinRoute;
    logic [7:0] irqLineSourceSelect;
    logic [7:0] irqFlags;
    logic [7:0] eventVec;
    logic [7:0] flagClear;
    logic [7:0] next_regRdata;
    logic [1:0] outPinFourRoute;
    logic [1:0] outPinThreeRoute;
    logic [1:0] outPinTwoRoute;
    logic [1:0] outPinOneRoute;
    logic [3:0] irqLineOneSource;
    logic [3:0] irqLineTwoSource;

    rxi_event_if evBus();

    assign eventVec[rxi_pkg::BIT_SLEEP_TIMEOUT]  = sleepTimeoutEvent;
    assign eventVec[rxi_pkg::BIT_RECV_TIMEOUT]   = receiveTimeoutEvent;
    assign eventVec[rxi_pkg::BIT_SIGNAL_VALID]   = signalValidEvent;
    assign eventVec[rxi_pkg::BIT_PREAMBLE_PASS]  = preamblePassEvent;
    assign eventVec[rxi_pkg::BIT_SYNCWORD_PASS]  = syncwordPassEvent;
    assign eventVec[rxi_pkg::BIT_NODE_MATCH]     = nodeMatchEvent;
    assign eventVec[rxi_pkg::BIT_CHECKSUM_PASS]  = checksumPassEvent;
    assign eventVec[rxi_pkg::BIT_FRAME_FINISHED] = frameFinishedEvent;

    assign outPinFourRoute  = outputPinRoute[rxi_pkg::POS_OUT_PIN_FOUR_ROUTE +: 2];
    assign outPinThreeRoute = outputPinRoute[rxi_pkg::POS_OUT_PIN_THREE_ROUTE +: 2];
    assign outPinTwoRoute   = outputPinRoute[rxi_pkg::POS_OUT_PIN_TWO_ROUTE +: 2];
    assign outPinOneRoute   = outputPinRoute[rxi_pkg::POS_OUT_PIN_ONE_ROUTE +: 2];
    assign irqLineTwoSource = irqLineSourceSelect[rxi_pkg::POS_IRQ_LINE_TWO_SOURCE +: 4];
    assign irqLineOneSource = irqLineSourceSelect[rxi_pkg::POS_IRQ_LINE_ONE_SOURCE +: 4];

    // clear strobes last only for the write cycle; nothing is stored
    assign flagClear = (regWrite && regAddr == rxi_pkg::ADDR_IRQ_FLAG_CLEAR) ? regWdata : 8'h00;

    // writable registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqEnableMask       <= rxi_pkg::RST_IRQ_ENABLE_MASK;
            outputPinRoute      <= rxi_pkg::RST_OUTPUT_PIN_ROUTE;
            irqLineSourceSelect <= rxi_pkg::RST_IRQ_LINE_SRC_SEL;
        end
        else if (regWrite)
        begin
            if (regAddr == rxi_pkg::ADDR_IRQ_ENABLE_MASK)
                irqEnableMask <= regWdata;
            if (regAddr == rxi_pkg::ADDR_OUTPUT_PIN_ROUTE)
                outputPinRoute <= regWdata;
            if (regAddr == rxi_pkg::ADDR_IRQ_LINE_SRC_SEL)
                irqLineSourceSelect <= regWdata;
        end
    end

    // latched flags: an event in the clear cycle survives; the byte write
    // pulse is deliberately absent from this vector
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            irqFlags <= rxi_pkg::RST_IRQ_FLAGS;
        else
            irqFlags <= (irqFlags & ~flagClear) | (eventVec & irqEnableMask);
    end

    // read data is valid the cycle after the read strobe
    always_comb
    begin
        next_regRdata = 8'h00;
        if (regRead)
        begin
            case (regAddr)
                rxi_pkg::ADDR_IRQ_ENABLE_MASK:   next_regRdata = irqEnableMask;
                rxi_pkg::ADDR_OUTPUT_PIN_ROUTE:  next_regRdata = outputPinRoute;
                rxi_pkg::ADDR_IRQ_LINE_SRC_SEL:  next_regRdata = irqLineSourceSelect;
                rxi_pkg::ADDR_IRQ_FLAG_REGISTER: next_regRdata = irqFlags;
                default:                         next_regRdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            regRdata <= 8'h00;
        else
            regRdata <= next_regRdata;
    end

    assign evBus.dataMode                = dataMode;
    assign evBus.flags                   = irqFlags;
    assign evBus.signalStrengthIndicator = signalStrengthIndicator;
    assign evBus.queueNotEmpty           = queueNotEmpty;
    assign evBus.queueThreshold          = queueThreshold;
    assign evBus.queueFull               = queueFull;
    assign evBus.queueByteWriteStrobe    = queueByteWriteStrobe;
    assign evBus.queueOverflow           = queueOverflow;

    rxi_line_mux u_lineOne
    (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .sourceCode (irqLineOneSource),
        .ev         (evBus),
        .irqLine    (irqLineOne)
    );

    rxi_line_mux u_lineTwo
    (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .sourceCode (irqLineTwoSource),
        .ev         (evBus),
        .irqLine    (irqLineTwo)
    );

    // pins are retimed, so routed clocks are limited to half of clk_sys
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outPinOne   <= 1'b0;
            outPinTwo   <= 1'b0;
            outPinThree <= 1'b0;
            outPinFour  <= 1'b0;
        end
        else
        begin
            case (outPinFourRoute)
                rxi_pkg::ROUTE_DEFAULT: outPinFour <= demodData;
                rxi_pkg::ROUTE_ALT_ONE: outPinFour <= irqLineOne;
                rxi_pkg::ROUTE_ALT_TWO: outPinFour <= irqLineTwo;
                default:                outPinFour <= dataSyncClock;
            endcase
            case (outPinThreeRoute)
                rxi_pkg::ROUTE_DEFAULT: outPinThree <= systemClockOut;
                rxi_pkg::ROUTE_ALT_ONE: outPinThree <= irqLineOne;
                rxi_pkg::ROUTE_ALT_TWO: outPinThree <= irqLineTwo;
                default:                outPinThree <= demodData;
            endcase
            case (outPinTwoRoute)
                rxi_pkg::ROUTE_DEFAULT: outPinTwo <= irqLineOne;
                rxi_pkg::ROUTE_ALT_ONE: outPinTwo <= irqLineTwo;
                rxi_pkg::ROUTE_ALT_TWO: outPinTwo <= dataSyncClock;
                default:                outPinTwo <= 1'b0;
            endcase
            case (outPinOneRoute)
                rxi_pkg::ROUTE_DEFAULT: outPinOne <= powerOnResetOut;
                rxi_pkg::ROUTE_ALT_ONE: outPinOne <= irqLineOne;
                rxi_pkg::ROUTE_ALT_TWO: outPinOne <= irqLineTwo;
                default:                outPinOne <= demodData;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    for (genvar i = 0; i < 8; i++)
    begin : g_flagChk
        a_flag_gated: assert property (
            (!irqEnableMask[i] && !irqFlags[i]) |=> !irqFlags[i])
            else $error("flag set while its enable was off");
        a_flag_set_wins: assert property (
            (irqEnableMask[i] && eventVec[i]) |=> irqFlags[i])
            else $error("enabled event did not set its flag");
        a_flag_clear_one: assert property (
            (flagClear[i] && !(irqEnableMask[i] && eventVec[i])) |=> !irqFlags[i])
            else $error("writing one did not clear the flag");
    end

    a_pin_four_sync: assert property (
        (outPinFourRoute == 2'h3) |=> (outPinFour == $past(dataSyncClock)))
        else $error("pin four does not follow sync clock");
    a_pin_three_clock: assert property (
        (outPinThreeRoute == 2'h0) |=> (outPinThree == $past(systemClockOut)))
        else $error("pin three does not follow clock out");
    a_pin_two_zero: assert property (
        (outPinTwoRoute == 2'h3) |=> !outPinTwo)
        else $error("pin two not zero on code three");
    a_pin_one_line: assert property (
        (outPinOneRoute == 2'h1) |=> (outPinOne == $past(irqLineOne)))
        else $error("pin one does not follow line one");
    a_line_sync_code: assert property (
        (irqLineOneSource == 4'h3) |=> (irqLineOne == $past(irqFlags[3])))
        else $error("line one does not show sync word flag");
    a_direct_high_zero: assert property (
        (dataMode == 2'h0 && irqLineTwoSource >= 4'h7) |=> !irqLineTwo)
        else $error("line two active on unused direct mode code");
    a_buffer_wbyte_pulse: assert property (
        (dataMode == 2'h1 && irqLineTwoSource == 4'h9 && !queueByteWriteStrobe)
            |=> !irqLineTwo)
        else $error("byte write pulse held on line two");
    a_packet_frame_done: assert property (
        (dataMode == 2'h2 && irqLineTwoSource == 4'h6) |=> (irqLineTwo == $past(irqFlags[0])))
        else $error("line two does not show frame finished flag");
    a_code_fifteen_zero: assert property (
        (irqLineOneSource == 4'hF) |=> !irqLineOne)
        else $error("line one not zero on code fifteen");
    a_buffer_code_twelve: assert property (
        (dataMode == 2'h1 && irqLineTwoSource == 4'hC) |=> !irqLineTwo)
        else $error("line two active on unused buffer mode code");
    a_pin_four_line: assert property (
        (outPinFourRoute == 2'h1) |=> (outPinFour == $past(irqLineOne)))
        else $error("pin four does not follow line one");
    a_pin_three_data: assert property (
        (outPinThreeRoute == 2'h3) |=> (outPinThree == $past(demodData)))
        else $error("pin three does not follow data");
    a_pin_two_sync: assert property (
        (outPinTwoRoute == 2'h2) |=> (outPinTwo == $past(dataSyncClock)))
        else $error("pin two does not follow sync clock");
    a_pin_one_reset: assert property (
        (outPinOneRoute == 2'h0) |=> (outPinOne == $past(powerOnResetOut)))
        else $error("pin one does not follow reset out");
    a_line_two_zero: assert property (
        (irqLineTwoSource == 4'h0) |=> !irqLineTwo)
        else $error("line two not zero on code zero");
    a_line_two_valid: assert property (
        (irqLineTwoSource == 4'h1) |=> (irqLineTwo == $past(irqFlags[5])))
        else $error("line two does not show signal valid flag");
    a_direct_sleep_code: assert property (
        (dataMode == 2'h0 && irqLineOneSource == 4'h4) |=> (irqLineOne == $past(irqFlags[7])))
        else $error("line one does not show sleep timeout flag");
    a_buffer_indicator: assert property (
        (dataMode == 2'h1 && irqLineTwoSource == 4'hB)
            |=> (irqLineTwo == $past(signalStrengthIndicator)))
        else $error("line two does not show indicator in buffer mode");
    a_packet_node_code: assert property (
        (dataMode == 2'h2 && irqLineOneSource == 4'h4) |=> (irqLineOne == $past(irqFlags[2])))
        else $error("line one does not show node match flag");
    a_packet_indicator: assert property (
        (dataMode == 2'h2 && irqLineTwoSource == 4'hE)
            |=> (irqLineTwo == $past(signalStrengthIndicator)))
        else $error("line two does not show indicator in packet mode");
    a_line_two_fifteen: assert property (
        (irqLineTwoSource == 4'hF) |=> !irqLineTwo)
        else $error("line two not zero on code fifteen");

endmodule

// *** bench/rxi_host_model.sv ***
`timescale 1ns/10ps
module rxi_host_model
(
    // clock
    input  wire logic       clk_sys,
    // host register port
    output logic            regWrite,
    output logic            regRead,
    output logic      [6:0] regAddr,
    output logic      [7:0] regWdata,
    input  wire logic [7:0] regRdata
);
    initial
    begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regAddr  = 7'h00;
        regWdata = 8'h00;
    end

    // released address and data show the inverse, never the last value
    // a write of ones to the clear address is how the host drops flags
    task automatic writeReg(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        regWrite = 1'b1;
        regAddr  = a;
        regWdata = d;
        @(posedge clk_sys);
        #1;
        regWrite = 1'b0;
        regAddr  = ~a;
        regWdata = ~d;
    endtask

    // read data is registered, so it is taken one edge after the strobe
    task automatic readReg(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        regRead = 1'b1;
        regAddr = a;
        @(posedge clk_sys);
        #1;
        regRead = 1'b0;
        regAddr = ~a;
        d       = regRdata;
    endtask
endmodule

// *** bench/rx_irq_enable_and_output_routing_tb.sv ***
`timescale 1ns/10ps
module rx_irq_enable_and_output_routing_tb;
    localparam logic [6:0] A_EN  = rxi_pkg::ADDR_IRQ_ENABLE_MASK;
    localparam logic [6:0] A_RT  = rxi_pkg::ADDR_OUTPUT_PIN_ROUTE;
    localparam logic [6:0] A_SEL = rxi_pkg::ADDR_IRQ_LINE_SRC_SEL;
    localparam logic [6:0] A_CLR = rxi_pkg::ADDR_IRQ_FLAG_CLEAR;
    localparam logic [6:0] A_FLG = rxi_pkg::ADDR_IRQ_FLAG_REGISTER;
    // source index per {mode,code}: 0..7 flags, 8 indicator, 9..13 queue, 15 zero
    localparam int SRC_TBL [64] = '{15,5,4,3,7,6,8,15,15,15,15,15,15,15,15,15,
                                    15,5,4,3,7,6,9,10,11,12,13,8,15,15,15,15,
                                    15,5,4,3,2,1,0,7,6,9,10,11,12,13,8,15,
                                    15,5,4,3,15,15,15,15,15,15,15,15,15,15,15,15};
    localparam int PIN4 [4] = '{0,4,5,1};
    localparam int PIN3 [4] = '{2,4,5,0};
    localparam int PIN2 [4] = '{4,5,1,6};
    localparam int PIN1 [4] = '{3,4,5,0};

    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       regWrite;
    logic       regRead;
    logic [6:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic [1:0] dataMode = rxi_pkg::MODE_DIRECT;
    logic [7:0] ev = 8'h00;
    logic [5:0] raw = 6'h00;
    logic [3:0] offer = 4'h0;
    logic       irqLineOne;
    logic       irqLineTwo;
    logic [3:0] pins;
    int         fail_count = 0;
    int         check_count = 0;

    always #4 clk_sys = ~clk_sys;

    rxi_host_model u_rxi_host_model
    (
        .clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata)
    );

    rxi_irq_route u_rxi_irq_route
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .dataMode(dataMode),
        .sleepTimeoutEvent(ev[7]), .receiveTimeoutEvent(ev[6]), .signalValidEvent(ev[5]),
        .preamblePassEvent(ev[4]), .syncwordPassEvent(ev[3]), .nodeMatchEvent(ev[2]),
        .checksumPassEvent(ev[1]), .frameFinishedEvent(ev[0]),
        .signalStrengthIndicator(raw[0]), .queueNotEmpty(raw[1]), .queueThreshold(raw[2]),
        .queueFull(raw[3]), .queueByteWriteStrobe(raw[4]), .queueOverflow(raw[5]),
        .demodData(offer[0]), .dataSyncClock(offer[1]), .systemClockOut(offer[2]),
        .powerOnResetOut(offer[3]), .irqLineOne(irqLineOne), .irqLineTwo(irqLineTwo),
        .outPinOne(pins[0]), .outPinTwo(pins[1]), .outPinThree(pins[2]), .outPinFour(pins[3])
    );

    task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // latch a flag pattern, then mask everything so the flags stay put
    task automatic loadFlags(input logic [7:0] en, input logic [7:0] f);
        u_rxi_host_model.writeReg(A_CLR, 8'hFF);
        u_rxi_host_model.writeReg(A_EN, en);
        @(posedge clk_sys);
        #1;
        ev = f;
        @(posedge clk_sys);
        #1;
        ev = 8'h00;
        u_rxi_host_model.writeReg(A_EN, 8'h00);
    endtask

    task automatic t_regs();
        logic [6:0] a;
        logic [7:0] d;
        for (int i = 0; i < 4; i++)
        begin
            a = (i == 3) ? 7'h50 : A_EN + 7'(i);
            u_rxi_host_model.readReg(a, d);
            expect8(d, 8'h00);
            u_rxi_host_model.writeReg(a, 8'hA5);
            u_rxi_host_model.readReg(a, d);
            expect8(d, (i == 3) ? 8'h00 : 8'hA5);
            u_rxi_host_model.writeReg(a, 8'h00);
        end
    endtask

    // each event is offered at once, only the enabled one may latch
    task automatic t_gating();
        logic [7:0] d;
        for (int i = 0; i < 8; i++)
        begin
            loadFlags(8'h01 << i, 8'hFF);
            u_rxi_host_model.readReg(A_FLG, d);
            expect8(d, 8'h01 << i);
            u_rxi_host_model.writeReg(A_CLR, 8'h01 << i);
            u_rxi_host_model.readReg(A_FLG, d);
            expect8(d, 8'h00);
        end
    endtask

    // each source but index 12 (byte write strobe) and 15 (zero) carries a distinct 4-bit code across four patterns
    task automatic t_sources();
        logic [15:0] v;
        int          e;
        for (int p = 0; p < 4; p++)
        begin
            for (int k = 0; k < 16; k++)
                v[k] = ((k + 1) >> p) & 1;
            v[12] = 1'b0;
            v[15] = 1'b0;
            loadFlags(8'hFF, v[7:0]);
            raw = {v[13], 1'b0, v[11:8]};
            for (int m = 0; m < 4; m++)
            begin
                dataMode = 2'(m);
                for (int c = 0; c < 16; c++)
                begin
                    u_rxi_host_model.writeReg(A_SEL, {4'(c), 4'(15 - c)});
                    repeat (2) @(posedge clk_sys);
                    #1;
                    e = SRC_TBL[m * 16 + c];
                    expect8({7'h00, irqLineTwo}, {7'h00, v[e]});
                    e = SRC_TBL[m * 16 + 15 - c];
                    expect8({7'h00, irqLineOne}, {7'h00, v[e]});
                end
            end
        end
        raw = 6'h00;
    endtask

    task automatic t_strobe();
        logic [7:0] d;
        int         n;
        n = 0;
        dataMode = rxi_pkg::MODE_BUFFER;
        loadFlags(8'hFF, 8'h00);
        // enables stay on so a latched strobe would show in the flags
        u_rxi_host_model.writeReg(A_EN, 8'hFF);
        u_rxi_host_model.writeReg(A_SEL, 8'h99);
        @(posedge clk_sys);
        #1;
        raw[4] = 1'b1;
        repeat (6)
        begin
            @(posedge clk_sys);
            #1;
            raw[4] = 1'b0;
            #1;
            n += int'(irqLineOne === 1'b1) + int'(irqLineTwo === 1'b1);
        end
        expect8(8'(n), 8'h02);
        u_rxi_host_model.readReg(A_FLG, d);
        expect8(d, 8'h00);
    endtask

    // six pin candidates carry distinct 3-bit codes, index 6 is constant zero
    task automatic t_pins();
        logic [6:0] s;
        logic [3:0] e;
        dataMode = rxi_pkg::MODE_BUFFER;
        u_rxi_host_model.writeReg(A_SEL, 8'hA8);
        for (int c = 0; c < 4; c++)
        begin
            u_rxi_host_model.writeReg(A_RT, {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)});
            for (int p = 0; p < 3; p++)
            begin
                for (int k = 0; k < 7; k++)
                    s[k] = (k < 6) ? (((k + 1) >> p) & 1) : 1'b0;
                offer = s[3:0];
                raw = {s[5], 1'b0, s[4], 3'h0};
                repeat (3) @(posedge clk_sys);
                #1;
                e = {s[PIN4[(c + 3) % 4]], s[PIN3[(c + 2) % 4]], s[PIN2[(c + 1) % 4]],
                     s[PIN1[c]]};
                expect8({4'h0, pins}, {4'h0, e});
            end
        end
    endtask

    initial
    begin
        #400000;
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_regs();
        t_gating();
        t_sources();
        t_strobe();
        t_pins();
        report_and_stop();
    end
endmodule
